// [hw/mac_tx_flow_backpressure.sv]
// Transmit MAC: gap, back-off, collisions, pause, flow control, backpressure.
// Assumes a PHY byte port paced here, a frame source that restarts on
// rewind and skips on drop, and receive logic reporting pause frames.
`timescale 1ns/1ps
`include "mac_tx_defs.svh"
`default_nettype none
module mac_tx_flow_backpressure import mac_tx_pkg::*; #(
   parameter int BP_ON_BITS = `BP_ON_BITS_DEF, // Carrier on time, bits
   parameter logic [47:0] STATION_ADDR = 48'h020000000001 // Arbitrary
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   input wire logic duplex_full_in,
   input wire logic speed_100_in,
   input wire logic crs_in,
   input wire logic col_in,
   input wire logic bp_enable_in,
   input wire logic pause_rx_valid_in,
   input wire logic [15:0] pause_rx_quanta_in,
   input wire logic [15:0] rxq_free_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_last_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   output logic tx_done_out,
   output logic tx_rewind_out,
   output logic tx_drop_out,
   output logic phy_tx_en_out,
   output logic [7:0] phy_txd_out,
   output logic rx_drop_out,
   output logic flow_active_out,
   output logic paused_out
);
   // -------------------------------------------------
   // Declarations
   // -------------------------------------------------
   logic [3:0] sync_a; // First synchroniser stage
   logic [3:0] sync_b; // Second synchroniser stage
   logic crs_s, col_s, duplex_s, speed_s;
   logic half; // Half duplex link
   logic [3:0] div; // Bit time divider
   logic bit_tick; // One bit time passed
   logic [2:0] bit_idx;
   logic byte_tick; // One byte time passed
   logic [15:0] lfsr; // Back-off random source
   tx_state_t state;
   tx_state_t tail_next; // State after carrier drops
   frame_kind_t kind;
   logic [5:0] byte_idx;
   logic [9:0] frame_bits; // Bits since frame start
   logic [6:0] gap_cnt;
   logic [19:0] tmr; // Back-off or carrier timer
   logic [4:0] attempts; // Collisions of this frame
   logic coll_seen;
   logic [15:0] quanta_cnt; // Pause quanta left
   logic [8:0] quanta_sub; // Bits within a quantum
   logic fc_active; // Flow control invoked
   logic fc_prev;
   logic xoff_pend, xon_pend;
   logic bp_active;
   logic col_hit;
   logic pause_start, xoff_take, xon_take;
   logic flush;
   logic [3:0] bo_exp;
   logic [9:0] bo_mask;
   logic [15:0] low_wm, high_wm, ovr_wm;

   byte_stream_if up_if ();
   byte_stream_if dn_if ();

   // -------------------------------------------------
   // Byte path buffer
   // -------------------------------------------------
   assign up_if.valid = tx_valid_in;
   assign up_if.data = tx_data_in;
   assign up_if.last = tx_last_in;
   assign tx_ready_out = up_if.ready;
   assign dn_if.ready = byte_tick && (state == ST_DATA) &&
      (kind == KIND_NORMAL) && !col_hit;
   assign flush = col_hit;

   two_entry_buffer u_buf (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .flush_in(flush),
      .fill_in(up_if),
      .drain_out(dn_if)
   );

   // -------------------------------------------------
   // Pin synchronisers and bit timing
   // -------------------------------------------------
   // Two stages for the speed, duplex, col and crs pin levels
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
      end else begin
         sync_a <= {speed_100_in, duplex_full_in, col_in, crs_in};
         sync_b <= sync_a;
      end
   end
   assign {speed_s, duplex_s, col_s, crs_s} = sync_b;
   assign half = !duplex_s;

   // Bit tick per link speed
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div <= 4'h0;
         bit_idx <= 3'h0;
      end else begin
         if (div == 4'h0) begin
            div <= speed_s ? 4'(`BIT_NS_100M / `CLK_PERIOD_NS - 1) :
               4'(`BIT_NS_10M / `CLK_PERIOD_NS - 1);
            bit_idx <= bit_idx + 3'h1;
         end else begin
            div <= div - 4'h1;
         end
      end
   end
   assign bit_tick = (div == 4'h0);
   assign byte_tick = bit_tick && (bit_idx == 3'h7);

   // Free-running random source
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) lfsr <= `LFSR_SEED;
      else lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
   end

   // Back-off window for the next attempt
   assign bo_exp = (attempts >= 5'(`BACKOFF_LIMIT - 1)) ? 4'(`BACKOFF_LIMIT) :
      4'(attempts + 5'h1);
   assign bo_mask = 10'((11'h001 << bo_exp) - 11'h001);

   // -------------------------------------------------
   // Received pause timer
   // -------------------------------------------------
   // Load on pause frame, count down in quanta
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         quanta_cnt <= 16'h0000;
         quanta_sub <= 9'h000;
      end else if (pause_rx_valid_in && duplex_s) begin
         quanta_cnt <= pause_rx_quanta_in;
         quanta_sub <= 9'h000;
      end else if (quanta_cnt != 16'h0000 && bit_tick) begin
         quanta_sub <= quanta_sub + 9'h001;
         if (quanta_sub == 9'(`QUANTUM_BITS - 1)) begin
            quanta_cnt <= quanta_cnt - 16'h0001;
         end
      end
   end
   assign paused_out = (quanta_cnt != 16'h0000);

   // -------------------------------------------------
   // Watermark flow control
   // -------------------------------------------------
   // Hysteresis between high and low marks
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fc_active <= 1'b0;
         fc_prev <= 1'b0;
         rx_drop_out <= 1'b0;
      end else begin
         if (rxq_free_in <= high_wm) fc_active <= 1'b1;
         else if (rxq_free_in >= low_wm) fc_active <= 1'b0;
         fc_prev <= fc_active;
         rx_drop_out <= (rxq_free_in <= ovr_wm);
      end
   end
   assign flow_active_out = fc_active;
   assign bp_active = half && fc_active && bp_enable_in;

   // Pause frame requests; a new request wins over its clear
   assign pause_start = (state == ST_IDLE) && !half && (xoff_pend || xon_pend);
   assign xoff_take = pause_start && xoff_pend;
   assign xon_take = pause_start && !xoff_pend;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xoff_pend <= 1'b0;
         xon_pend <= 1'b0;
      end else begin
         if (fc_active && !fc_prev && !half) xoff_pend <= 1'b1;
         else if (xoff_take || half) xoff_pend <= 1'b0;
         if (!fc_active && fc_prev && !half) xon_pend <= 1'b1;
         else if (xon_take || half || (fc_active && !fc_prev)) xon_pend <= 1'b0;
      end
   end

   // Byte of an outgoing pause frame
   function automatic logic [7:0] pause_byte(input logic [5:0] idx,
                                             input frame_kind_t k);
      logic [15:0] ptime;
      logic [143:0] hdr;
      ptime = (k == KIND_XOFF) ? `PAUSE_TIME_XOFF : `PAUSE_TIME_XON;
      hdr = {`PAUSE_DA, STATION_ADDR, `PAUSE_TYPE, `PAUSE_OPCODE, ptime};
      if (idx < 6'h12) pause_byte = hdr[8'(143 - 8 * idx) -: 8];
      else pause_byte = 8'h00;
   endfunction

   // -------------------------------------------------
   // Transmit sequencer
   // -------------------------------------------------
   assign col_hit = half && col_s && (state == ST_PRE || state == ST_DATA);

   // Frame, jam, gap, back-off and carrier sequencing with PHY bytes
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         tail_next <= ST_GAP;
         kind <= KIND_NORMAL;
         byte_idx <= 6'h00;
         frame_bits <= 10'h000;
         gap_cnt <= 7'h00;
         tmr <= 20'h00000;
         attempts <= 5'h00;
         coll_seen <= 1'b0;
         phy_tx_en_out <= 1'b0;
         phy_txd_out <= 8'h00;
         tx_done_out <= 1'b0;
         tx_rewind_out <= 1'b0;
         tx_drop_out <= 1'b0;
      end else begin
         tx_done_out <= 1'b0;
         tx_rewind_out <= 1'b0;
         tx_drop_out <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               byte_idx <= 6'h00;
               frame_bits <= 10'h000;
               if (pause_start) begin
                  // Own pause frames ignore the pause timer
                  kind <= xoff_take ? KIND_XOFF : KIND_XON;
                  state <= ST_PRE;
               end else if (dn_if.valid && !paused_out && !(half && crs_s)) begin
                  kind <= KIND_NORMAL;
                  state <= ST_PRE;
               end else if (bp_active) begin
                  tmr <= 20'h00000;
                  state <= ST_BP_ON;
               end
            end
            ST_PRE, ST_DATA: begin
               if (bit_tick && frame_bits != 10'h3FF) frame_bits <= frame_bits + 10'h001;
               if (col_hit) begin
                  coll_seen <= 1'b1;
                  byte_idx <= 6'h00;
                  state <= ST_JAM;
                  if (frame_bits >= 10'(`SLOT_BITS)) begin
                     tx_drop_out <= 1'b1;
                     attempts <= 5'h00;
                     tail_next <= ST_GAP;
                  end else if (attempts == 5'(`MAX_ATTEMPTS - 1)) begin
                     tx_drop_out <= 1'b1;
                     attempts <= 5'h00;
                     tail_next <= ST_GAP;
                  end else begin
                     tx_rewind_out <= 1'b1;
                     attempts <= attempts + 5'h01;
                     tmr <= {1'b0, lfsr[9:0] & bo_mask, 9'h000};
                     tail_next <= bp_active ? ST_BP_ON : ST_BACKOFF;
                  end
               end else if (byte_tick) begin
                  phy_tx_en_out <= 1'b1;
                  if (state == ST_PRE) begin
                     phy_txd_out <= (byte_idx == 6'(`PREAMBLE_BYTES - 1)) ?
                        `SFD_BYTE : `PREAMBLE_BYTE;
                     byte_idx <= byte_idx + 6'h01;
                     if (byte_idx == 6'(`PREAMBLE_BYTES - 1)) begin
                        byte_idx <= 6'h00;
                        state <= ST_DATA;
                     end
                  end else if (kind == KIND_NORMAL) begin
                     if (dn_if.valid) begin
                        phy_txd_out <= dn_if.data;
                        if (dn_if.last) begin
                           tx_done_out <= 1'b1;
                           attempts <= 5'h00;
                           tail_next <= ST_GAP;
                           state <= ST_TAIL;
                        end
                     end
                  end else begin
                     phy_txd_out <= pause_byte(byte_idx, kind);
                     byte_idx <= byte_idx + 6'h01;
                     if (byte_idx == 6'(`PAUSE_LAST_BYTE)) begin
                        tail_next <= ST_GAP;
                        state <= ST_TAIL;
                     end
                  end
               end
            end
            ST_JAM: begin
               if (byte_tick) begin
                  phy_tx_en_out <= 1'b1;
                  phy_txd_out <= `PREAMBLE_BYTE;
                  byte_idx <= byte_idx + 6'h01;
                  if (byte_idx == 6'(`JAM_BYTES - 1)) begin
                     // Under backpressure the carrier simply continues
                     if (tail_next == ST_BP_ON) begin
                        tmr <= 20'h00000;
                        state <= ST_BP_ON;
                     end else begin
                        state <= ST_TAIL;
                     end
                  end
               end
            end
            ST_TAIL: begin
               if (byte_tick) begin
                  phy_tx_en_out <= 1'b0;
                  phy_txd_out <= 8'h00;
                  gap_cnt <= 7'h00;
                  if (tail_next != ST_BACKOFF) tmr <= 20'h00000;
                  state <= tail_next;
               end
            end
            ST_BACKOFF: begin
               if (bit_tick) begin
                  if (tmr == 20'h00000) begin
                     gap_cnt <= 7'h00;
                     state <= ST_GAP;
                  end else begin
                     tmr <= tmr - 20'h00001;
                  end
               end
            end
            ST_GAP: begin
               if (bit_tick) begin
                  if (half && coll_seen && crs_s) begin
                     gap_cnt <= 7'h00;
                  end else if (gap_cnt == 7'(`IPG_BITS - 1)) begin
                     coll_seen <= 1'b0;
                     state <= ST_IDLE;
                  end else begin
                     gap_cnt <= gap_cnt + 7'h01;
                  end
               end
            end
            ST_BP_ON: begin
               // Own collisions here are ignored: carrier is held
               if (bit_tick) tmr <= tmr + 20'h00001;
               if (byte_tick) begin
                  if (!bp_active || dn_if.valid) begin
                     tail_next <= ST_GAP;
                     state <= ST_TAIL;
                  end else if (tmr >= 20'(BP_ON_BITS)) begin
                     tail_next <= ST_BP_OFF;
                     state <= ST_TAIL;
                  end else begin
                     phy_tx_en_out <= 1'b1;
                     phy_txd_out <= `PREAMBLE_BYTE;
                  end
               end
            end
            ST_BP_OFF: begin
               // Silence shorter than a gap keeps others deferred
               if (bit_tick) begin
                  tmr <= tmr + 20'h00001;
                  if (tmr == 20'(`BP_OFF_BITS - 1)) begin
                     tmr <= 20'h00000;
                     gap_cnt <= 7'h00;
                     state <= (bp_active && !dn_if.valid) ? ST_BP_ON : ST_GAP;
                  end
               end
            end
         endcase
      end
   end

   // -------------------------------------------------
   // Registers
   // -------------------------------------------------
   // Watermark writes
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_wm <= `LOW_WM_RST;
         high_wm <= `HIGH_WM_RST;
         ovr_wm <= `OVR_WM_RST;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `REG_LOW_WM_OFS) low_wm <= reg_wdata_in;
         if (reg_addr_in == `REG_HIGH_WM_OFS) high_wm <= reg_wdata_in;
         if (reg_addr_in == `REG_OVR_WM_OFS) ovr_wm <= reg_wdata_in;
      end
   end

   // Registered reads; unmapped reads zero
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `REG_LOW_WM_OFS: reg_rdata_out <= low_wm;
            `REG_HIGH_WM_OFS: reg_rdata_out <= high_wm;
            `REG_OVR_WM_OFS: reg_rdata_out <= ovr_wm;
            `REG_STATUS_OFS: reg_rdata_out <= {3'h0, attempts, 4'h0,
               rx_drop_out, (state == ST_BP_ON), paused_out, fc_active};
            default: reg_rdata_out <= 16'h0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// [hw/mac_tx_defs.svh]
// Constants of the transmit MAC: offsets, reset values, timing counts.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef MAC_TX_DEFS_SVH
`define MAC_TX_DEFS_SVH
// -------------------------------------------------
// Register offsets and reset values (bytes free)
// -------------------------------------------------
`define REG_LOW_WM_OFS 8'hB0
`define REG_HIGH_WM_OFS 8'hB2
`define REG_OVR_WM_OFS 8'hB4
`define REG_STATUS_OFS 8'hB6
`define LOW_WM_RST 16'h1400
`define HIGH_WM_RST 16'h0C00
`define OVR_WM_RST 16'h0100
// -------------------------------------------------
// Timing: clock period, bit times, counts in bits, jam bytes and attempt limits
// -------------------------------------------------
`define CLK_PERIOD_NS 10
`define BIT_NS_10M 100
`define BIT_NS_100M 10
`define IPG_BITS 96
`define SLOT_BITS 512
`define QUANTUM_BITS 512
`define JAM_BYTES 4
`define MAX_ATTEMPTS 16
`define BACKOFF_LIMIT 10
`define BP_ON_BITS_DEF 20000
`define BP_OFF_BITS 48
// -------------------------------------------------
// Frame layout
// -------------------------------------------------
`define PREAMBLE_BYTES 8
`define PREAMBLE_BYTE 8'h55
`define SFD_BYTE 8'hD5
`define PAUSE_LAST_BYTE 59
`define PAUSE_DA 48'h0180C2000001
`define PAUSE_TYPE 16'h8808
`define PAUSE_OPCODE 16'h0001
`define PAUSE_TIME_XOFF 16'hFFFF
`define PAUSE_TIME_XON 16'h0000
`define LFSR_SEED 16'hACE1
`endif

// [hw/mac_tx_pkg.sv]
// Types shared by the transmit MAC files.
// Assumes nothing of its surroundings.
package mac_tx_pkg;
   // Transmit sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_PRE, ST_DATA, ST_JAM, ST_TAIL,
      ST_BACKOFF, ST_GAP, ST_BP_ON, ST_BP_OFF
   } tx_state_t;
   // What the current frame is
   typedef enum logic [1:0] {KIND_NORMAL, KIND_XOFF, KIND_XON} frame_kind_t;
endpackage

// [hw/byte_stream_if.sv]
// Byte stream with valid and ready between the MAC's own modules.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
   logic valid; // Byte offered
   logic ready; // Byte accepted
   logic last;  // Final byte of frame
   logic [7:0] data;
   modport src (output valid, output data, output last, input ready);
   modport snk (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// [hw/two_entry_buffer.sv]
// Two-entry buffer in the transmit byte path, with flush.
// Assumes fill and drain on the same clock; flush wins over a push.
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic flush_in,
   byte_stream_if.snk fill_in,
   byte_stream_if.src drain_out
);
   logic [8:0] slot [2]; // Stored {last, data}
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   assign fill_in.ready = (count != 2'h2);
   assign drain_out.valid = (count != 2'h0);
   assign drain_out.data = slot[rd_ptr][7:0];
   assign drain_out.last = slot[rd_ptr][8];
   assign push = fill_in.valid && fill_in.ready;
   assign pop = drain_out.valid && drain_out.ready;

   // Pointers and occupancy
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else if (flush_in) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         if (push && !pop) count <= count + 2'h1;
         else if (pop && !push) count <= count - 2'h1;
      end
   end

   // Storage
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slot[0] <= 9'h000;
         slot[1] <= 9'h000;
      end else if (push && !flush_in) begin
         slot[wr_ptr] <= {fill_in.last, fill_in.data};
      end
   end
endmodule
`default_nettype wire

// [tb/mac_tx_flow_backpressure_monitor.sv]
// Checker on the transmit MAC top ports.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mac_tx_monitor (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic duplex_full_in,
   input wire logic speed_100_in,
   input wire logic bp_enable_in,
   input wire logic pause_rx_valid_in,
   input wire logic [15:0] pause_rx_quanta_in,
   input wire logic [15:0] rxq_free_in,
   input wire logic phy_tx_en_out,
   input wire logic [7:0] phy_txd_out,
   input wire logic rx_drop_out,
   input wire logic flow_active_out,
   input wire logic paused_out
);
   logic [15:0] lw, hw, ow; // Shadow watermarks
   logic [9:0] idle; // Idle cycles, saturating
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Follow watermark writes
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lw <= 16'h1400;
         hw <= 16'h0C00;
         ow <= 16'h0100;
      end else if (reg_wr_in) begin
         if (reg_addr_in == 8'hB0) lw <= reg_wdata_in;
         if (reg_addr_in == 8'hB2) hw <= reg_wdata_in;
         if (reg_addr_in == 8'hB4) ow <= reg_wdata_in;
      end
   end
   // Count cycles with the transmitter silent
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) idle <= 10'h3FF;
      else if (phy_tx_en_out) idle <= 10'h000;
      else if (idle != 10'h3FF) idle <= idle + 10'h001;
   end
   // Rest of a byte after a change
   sequence byte_rest;
      $stable(phy_txd_out)[*7];
   endsequence
   a_flow_set: assert property (
      !flow_active_out && rxq_free_in <= hw |=> flow_active_out) else $error("no flow set");
   a_flow_clear: assert property (
      flow_active_out && rxq_free_in >= lw && rxq_free_in > hw |=> !flow_active_out)
      else $error("no flow clear");
   a_rx_drop: assert property (
      1'b1 |=> rx_drop_out == ($past(rxq_free_in) <= $past(ow))) else $error("bad rx drop");
   a_pause_load: assert property (
      pause_rx_valid_in && duplex_full_in && pause_rx_quanta_in != 16'h0000 |=> paused_out)
      else $error("pause not loaded");
   a_pause_zero: assert property (
      pause_rx_valid_in && duplex_full_in && pause_rx_quanta_in == 16'h0000 |=> !paused_out)
      else $error("pause not reloaded");
   a_preamble_first: assert property (
      $rose(phy_tx_en_out) |-> phy_txd_out == 8'h55) else $error("no preamble");
   a_gap_min: assert property (
      $rose(phy_tx_en_out) && !bp_enable_in |-> idle >= 10'd96) else $error("short gap");
   a_byte_hold: assert property (
      $changed(phy_txd_out) && phy_tx_en_out && $past(phy_tx_en_out) && speed_100_in
      |=> byte_rest) else $error("byte not held");
endmodule
bind mac_tx_flow_backpressure mac_tx_monitor mon (.*);
`default_nettype wire

// [tb/link_partner_model.sv]
// Link partner seen through the PHY: carrier echo and collisions.
// Assumes the bench clears col_at_in after each wanted collision.
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic tx_en_in,
   input wire logic [15:0] col_at_in, // Cycle of collision, 0 none
   output logic crs_out,
   output logic col_out
);
   int n; // Cycles into the burst
   // Collide for 32 cycles at the commanded point
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         n <= 0;
         col_out <= 1'b0;
      end else begin
         n <= tx_en_in ? n + 1 : 0;
         col_out <= col_at_in != 0 && n >= col_at_in && n < col_at_in + 32;
      end
   end
   assign crs_out = tx_en_in | col_out; // Own carrier echoed
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Bench: registers, flow control, pause, collisions, backpressure.
// Assumes the monitor is bound and the partner model drives carrier.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic duplex_full_in = 1'b1, speed_100_in = 1'b1, bp_enable_in = 1'b0, crs_in, col_in;
   logic pause_rx_valid_in = 1'b0, tx_last_in = 1'b0, tx_valid_in = 1'b0, took = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, tx_data_in = 8'h00, phy_txd_out, cap [0:25];
   logic [15:0] reg_wdata_in = 16'h0000, pause_rx_quanta_in = 16'h0000, reg_rdata_out;
   logic [15:0] rxq_free_in = 16'h2000, col_at = 16'h0000;
   logic tx_ready_out, tx_done_out, tx_rewind_out, tx_drop_out, phy_tx_en_out;
   logic rx_drop_out, flow_active_out, paused_out;
   int fail_count = 0, checks = 0, cyc = 0, idx = 0, len = 0, req = 0, n;
   mac_tx_flow_backpressure #(.BP_ON_BITS(200)) dut (.*);
   link_partner_model lp (.sys_clk_in, .rst_n_in, .tx_en_in(phy_tx_en_out),
      .col_at_in(col_at), .crs_out(crs_in), .col_out(col_in));
   initial forever #5 sys_clk_in = ~sys_clk_in;
   // Cycle ceiling against hangs
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   // Frame source: restarts on rewind, ends on done or drop
   always @(posedge sys_clk_in) took <= tx_valid_in & tx_ready_out;
   always @(negedge sys_clk_in) begin
      if (tx_rewind_out) idx = 0;
      else if (took) idx++;
      if (tx_done_out | tx_drop_out) len = 0;
      if (len == 0 && req != 0) begin
         len = req;
         idx = 0;
         req = 0;
      end
      tx_valid_in = idx < len;
      tx_last_in = idx == len - 1;
      tx_data_in = 8'(idx);
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("fails %0d checks %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Strobe tasks idle one cycle first, so a strobe never falls and rises at once
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge sys_clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge sys_clk_in);
      reg_wr_in = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge sys_clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge sys_clk_in);
      reg_rd_in = 1'b0;
      chk(reg_rdata_out, e);
   endtask
   // Capture a pause frame up to its time field
   task grab(input logic [15:0] t);
      @(posedge sys_clk_in iff phy_tx_en_out);
      repeat (4) @(posedge sys_clk_in);
      for (int i = 0; i < 26; i++) begin
         cap[i] = phy_txd_out;
         repeat (8) @(posedge sys_clk_in);
      end
      chk({cap[20], cap[21]}, 16'h8808);
      chk({cap[24], cap[25]}, t);
      @(negedge sys_clk_in iff !phy_tx_en_out);
   endtask
   task pulse(input logic [15:0] q);
      @(negedge sys_clk_in);
      pause_rx_quanta_in = q;
      pause_rx_valid_in = 1'b1;
      @(negedge sys_clk_in);
      pause_rx_valid_in = 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      rd(8'hB0, 16'h1400);
      rd(8'hB2, 16'h0C00);
      rd(8'hB4, 16'h0100);
      rd(8'hB8, 16'h0000);
      wr(8'hB2, 16'h1000);
      rd(8'hB2, 16'h1000);
      rxq_free_in = 16'h0100;
      grab(16'hFFFF);
      chk(rx_drop_out, 1);
      chk(flow_active_out, 1);
      rxq_free_in = 16'h1300;
      repeat (4) @(negedge sys_clk_in);
      chk({rx_drop_out, flow_active_out}, 2'b01);
      rxq_free_in = 16'h1400;
      grab(16'h0000);
      chk(flow_active_out, 0);
      pulse(16'h0005);
      pulse(16'h0000);
      chk(paused_out, 0);
      req = 64;
      pulse(16'h0002);
      repeat (100) @(negedge sys_clk_in);
      pulse(16'h0001);
      repeat (500) @(negedge sys_clk_in);
      chk({paused_out, phy_tx_en_out}, 2'b10);
      repeat (30) @(negedge sys_clk_in);
      chk(paused_out, 0);
      @(negedge sys_clk_in iff tx_done_out);
      duplex_full_in = 1'b0;
      col_at = 16'h0028;
      req = 64;
      @(negedge sys_clk_in iff tx_rewind_out);
      col_at = 16'h0000;
      rd(8'hB6, 16'h0100);
      @(negedge sys_clk_in iff tx_done_out);
      col_at = 16'h0258;
      req = 100;
      @(negedge sys_clk_in iff (tx_drop_out | tx_done_out));
      chk(tx_drop_out, 1);
      col_at = 16'h0000;
      bp_enable_in = 1'b1;
      rxq_free_in = 16'h0100;
      @(negedge sys_clk_in iff !phy_tx_en_out);
      @(negedge sys_clk_in iff phy_tx_en_out);
      chk(phy_txd_out, 8'h55);
      n = 0;
      while (phy_tx_en_out) begin
         @(negedge sys_clk_in);
         n++;
      end
      chk(n <= 216, 1);
      n = 0;
      while (!phy_tx_en_out) begin
         @(negedge sys_clk_in);
         n++;
      end
      chk(n >= 48 && n <= 64, 1);
      req = 20;
      @(negedge sys_clk_in iff tx_done_out);
      @(negedge sys_clk_in iff !phy_tx_en_out);
      @(negedge sys_clk_in iff phy_tx_en_out);
      chk(phy_txd_out, 8'h55);
      print_verdict();
   end
endmodule
`default_nettype wire
